/* sector_guard_pkg.sv */
package sector_guard_pkg;

	// ----------------------------------------------------------------
	// Array geometry and bus widths
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int SECTOR_W = 8;
	localparam int SECTORS = 256;
	localparam logic [8:0] SECTORS_9 = 9'h100;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_CONFIG = 8'h04;
	localparam logic [7:0] REG_GUARD_MODE = 8'h08;
	localparam logic [7:0] REG_LOCK = 8'h0C;
	localparam logic [7:0] REG_SECTOR_SEL = 8'h10;
	localparam logic [7:0] REG_SECTOR_BITS = 8'h14;
	localparam logic [7:0] REG_PW_LO = 8'h18;
	localparam logic [7:0] REG_PW_HI = 8'h1C;
	localparam logic [7:0] REG_COMMAND = 8'h20;

	// ----------------------------------------------------------------
	// Field positions in read data
	// ----------------------------------------------------------------
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_WEL_BIT = 1;
	localparam int ST_LEVEL_LSB = 2;
	localparam int ST_ERR_BIT = 6;
	localparam int ST_SWD_BIT = 7;
	localparam int CF_FREEZE_BIT = 0;
	localparam int CF_TB_BIT = 5;
	localparam int MODE_LSB = 1;
	localparam int SB_PERSIST_BIT = 0;
	localparam int SB_DYNAMIC_BIT = 1;

	// ----------------------------------------------------------------
	// Command word layout
	// ----------------------------------------------------------------
	localparam int CMD_OP_LSB = 0;
	localparam int ARG_LEVEL_LSB = 8;
	localparam int ARG_SWD_BIT = 15;
	localparam int ARG_FREEZE_BIT = 16;
	localparam int ARG_TB_BIT = 21;
	localparam int ARG_DYB_BIT = 8;
	localparam int ARG_MODE_LSB = 9;

	// ----------------------------------------------------------------
	// Command opcodes
	// ----------------------------------------------------------------
	localparam logic [3:0] OP_WRITE_ENABLE = 4'h1;
	localparam logic [3:0] OP_REG_WRITE = 4'h2;
	localparam logic [3:0] OP_PERSIST_PROG = 4'h3;
	localparam logic [3:0] OP_PERSIST_ERASE = 4'h4;
	localparam logic [3:0] OP_DYNAMIC_WRITE = 4'h5;
	localparam logic [3:0] OP_LOCK_CLEAR = 4'h6;
	localparam logic [3:0] OP_PW_UNLOCK = 4'h7;
	localparam logic [3:0] OP_PW_PROG = 4'h8;
	localparam logic [3:0] OP_MODE_PROG = 4'h9;
	localparam logic [3:0] OP_CLEAR_STATUS = 4'hA;

	// ----------------------------------------------------------------
	// Guard mode codes and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] MODE_NONE = 2'h3;
	localparam logic [1:0] MODE_PERSIST = 2'h2;
	localparam logic [1:0] MODE_PASSWORD = 2'h1;
	localparam logic [1:0] MODE_ILLEGAL = 2'h0;
	localparam logic [2:0] LEVEL_RST = 3'h0;
	localparam logic [2:0] LEVEL_ALL = 3'h7;
	localparam logic [63:0] PW_RST = 64'hFFFF_FFFF_FFFF_FFFF;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam int T_UNLOCK_GAP_NS = 100000;
	localparam int UNLOCK_GAP_CYC = (T_UNLOCK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROG_CYC_DFLT = 1000;
	localparam int ERASE_CYC_DFLT = 5000;

	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_FAILED} op_state_t;

endpackage

/* sector_write_protection.sv */
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps

// Function
// - Range level plus selector gives protected range
// - Selector zero: upper fractions, 111 protects all
// - Selector one: same fractions from lowest address
// - Sector protected if range or sector bits
// - Lock bit freezes level and selector
// - Lock bit cleared only by power-on
// - Lock bit blocks all OTP programming
// - Level write under lock ignored, no error
// - Pin low with disable bit blocks register-write commands
// - Either sector bit zero blocks program/erase
// - Persistent lock zero fails persistent commands
// - Persistent mode: reset sets lock, clear-only
// - Password mode: reset clears, password sets lock
// - Mode bits: 11 default, 10 persistent, 01 password
// - Mode bits 00 is a programming failure
// - Chosen mode blocks further mode register changes
// - Busy flag covers mode and persistent operations
// - Fresh device: no mode chosen (11), all unprotected
// - Persistent bits programmed singly, erased together
// - Dynamic bits freely writable, zero protects
// - Software reset keeps persistent lock
// - Wrong password: error set, busy stays, lock kept
module sector_write_protection
	import sector_guard_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYC_DFLT,
	parameter int ERASE_CYC = ERASE_CYC_DFLT,
	parameter int UNLOCK_GAP = UNLOCK_GAP_CYC
) (
	// Clock and power-on reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Other resets
	input wire logic hw_rst_n_i,
	input wire logic soft_rst_i,
	// Write-protect pin
	input wire logic wp_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [DATA_W-1:0] reg_rdata_o,
	// Protection check from command decoder
	input wire logic chk_valid_i,
	input wire logic [SECTOR_W-1:0] chk_sector_i,
	input wire logic chk_otp_i,
	output logic chk_done_o,
	output logic chk_protected_o,
	// Status
	output logic busy_o,
	output logic prog_err_o
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic wp_n_s1_r, wp_n_s2_r, hw_n_s1_r, hw_n_s2_r;

	// Two stages each; only the second stage feeds logic
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			wp_n_s1_r <= 1'b1;
			wp_n_s2_r <= 1'b1;
			hw_n_s1_r <= 1'b1;
			hw_n_s2_r <= 1'b1;
		end else begin
			wp_n_s1_r <= wp_n_i;
			wp_n_s2_r <= wp_n_s1_r;
			hw_n_s1_r <= hw_rst_n_i;
			hw_n_s2_r <= hw_n_s1_r;
		end
	end

	logic hw_rst, any_rst;
	assign hw_rst = ~hw_n_s2_r;
	assign any_rst = hw_rst | soft_rst_i;

	// ----------------------------------------------------------------
	// State and command decode
	// ----------------------------------------------------------------
	logic [2:0] level_r;
	logic top_bottom_select_r, status_write_disable_r, freeze_r, write_enable_latch_r;
	logic [1:0] guard_mode_r;
	logic persist_lock_r, err_r;
	logic [SECTORS-1:0] persistent_sector_bit_r, dynamic_sector_bit_r;
	logic [SECTOR_W-1:0] sector_sel_r;
	logic [63:0] pw_hidden_r, pw_supplied_r;
	op_state_t state_r;
	logic [15:0] busy_cnt_r, gap_cnt_r;
	logic cmd_go, status_locked, regs_writable, needs_wel;
	logic cmd_run, cmd_fail, pw_match, pw_mode;
	logic [3:0] op;
	logic [15:0] cmd_cycles;

	assign cmd_go = reg_wr_i && (reg_addr_i == REG_COMMAND);
	assign op = reg_wdata_i[CMD_OP_LSB +: 4];
	assign status_locked = ~wp_n_s2_r & status_write_disable_r;
	assign pw_match = (pw_supplied_r == pw_hidden_r);
	assign pw_mode = (guard_mode_r == MODE_PASSWORD);
	assign needs_wel = (op == OP_REG_WRITE) || (op == OP_PERSIST_PROG) ||
		(op == OP_PERSIST_ERASE) || (op == OP_MODE_PROG) || (op == OP_PW_PROG);
	// Busy blocks new commands; only status clear gets through a failure
	assign regs_writable = (state_r == ST_IDLE) && !any_rst;

	// Which commands start a timed operation, and which fail outright
	always_comb begin
		cmd_run = 1'b0;
		cmd_fail = 1'b0;
		cmd_cycles = 16'h0001;
		if (cmd_go && regs_writable && (!needs_wel || write_enable_latch_r)) begin
			unique case (op)
				OP_PERSIST_PROG: begin
					cmd_run = persist_lock_r;
					cmd_fail = ~persist_lock_r;
					cmd_cycles = 16'(PROG_CYC);
				end
				OP_PERSIST_ERASE: begin
					cmd_run = persist_lock_r;
					cmd_fail = ~persist_lock_r;
					cmd_cycles = 16'(ERASE_CYC);
				end
				OP_MODE_PROG: begin
					cmd_fail = (guard_mode_r != MODE_NONE) ||
						(reg_wdata_i[ARG_MODE_LSB +: 2] == MODE_ILLEGAL);
					cmd_run = ~cmd_fail;
					cmd_cycles = 16'(PROG_CYC);
				end
				OP_PW_UNLOCK: begin
					// Retry gap still open: the attempt is not accepted at all
					cmd_fail = pw_mode && (gap_cnt_r == 16'h0000) && !pw_match;
					cmd_run = pw_mode && (gap_cnt_r == 16'h0000) && pw_match;
				end
				OP_PW_PROG: begin
					cmd_run = (guard_mode_r != MODE_PASSWORD);
					cmd_cycles = 16'(PROG_CYC);
				end
				default: begin
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Operation sequencer: busy and error
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || hw_rst) begin
			state_r <= ST_IDLE;
			busy_cnt_r <= 16'h0000;
			err_r <= 1'b0;
		end else begin
			unique case (state_r)
				ST_IDLE: begin
					if (cmd_fail) begin
						state_r <= ST_FAILED;
						err_r <= 1'b1;
					end else if (cmd_run) begin
						state_r <= ST_BUSY;
						busy_cnt_r <= cmd_cycles;
					end else if (cmd_go && op == OP_CLEAR_STATUS) begin
						err_r <= 1'b0;
					end
				end
				ST_BUSY: begin
					busy_cnt_r <= busy_cnt_r - 16'h0001;
					if (busy_cnt_r == 16'h0001) begin
						state_r <= ST_IDLE;
					end
				end
				ST_FAILED: begin
					// Stays busy with the error raised until status clear or a hardware reset
					if (cmd_go && op == OP_CLEAR_STATUS) begin
						state_r <= ST_IDLE;
						err_r <= 1'b0;
					end
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Password retry spacing, armed by a wrong password
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || hw_rst) begin
			gap_cnt_r <= 16'h0000;
		end else if (cmd_fail && op == OP_PW_UNLOCK) begin
			gap_cnt_r <= 16'(UNLOCK_GAP);
		end else if (gap_cnt_r != 16'h0000) begin
			gap_cnt_r <= gap_cnt_r - 16'h0001;
		end
	end

	// Latch set by its command, dropped by any reset
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || any_rst) begin
			write_enable_latch_r <= 1'b0;
		end else if (cmd_go && regs_writable) begin
			if (op == OP_WRITE_ENABLE) begin
				write_enable_latch_r <= 1'b1;
			end else if (needs_wel) begin
				write_enable_latch_r <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Protection state registers
	// ----------------------------------------------------------------
	logic reg_write_ok;
	assign reg_write_ok = cmd_go && regs_writable && (op == OP_REG_WRITE) &&
		write_enable_latch_r && !status_locked;

	// Level and selector hold while frozen; freeze only clears at power-on
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			level_r <= LEVEL_RST;
			top_bottom_select_r <= 1'b0;
			status_write_disable_r <= 1'b0;
			freeze_r <= 1'b0;
		end else if (reg_write_ok) begin
			status_write_disable_r <= reg_wdata_i[ARG_SWD_BIT];
			freeze_r <= freeze_r | reg_wdata_i[ARG_FREEZE_BIT];
			if (!freeze_r) begin
				level_r <= reg_wdata_i[ARG_LEVEL_LSB +: 3];
				top_bottom_select_r <= reg_wdata_i[ARG_TB_BIT];
			end
		end
	end

	// Reset stands in for factory state: no mode chosen, password all ones
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			guard_mode_r <= MODE_NONE;
		end else if (cmd_run && op == OP_MODE_PROG) begin
			guard_mode_r <= reg_wdata_i[ARG_MODE_LSB +: 2];
		end
	end

	// Password cells only ever program toward zero
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pw_hidden_r <= PW_RST;
		end else if (cmd_run && op == OP_PW_PROG) begin
			pw_hidden_r <= pw_hidden_r & pw_supplied_r;
		end
	end

	// Supplied value, used for both password program and unlock
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pw_supplied_r <= PW_RST;
		end else if (reg_wr_i && reg_addr_i == REG_PW_LO) begin
			pw_supplied_r[31:0] <= reg_wdata_i;
		end else if (reg_wr_i && reg_addr_i == REG_PW_HI) begin
			pw_supplied_r[63:32] <= reg_wdata_i;
		end
	end

	// Software reset does not touch it; mode picks its reset value
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			persist_lock_r <= 1'b1;
		end else if (hw_rst) begin
			persist_lock_r <= ~pw_mode;
		end else if (cmd_go && regs_writable && op == OP_LOCK_CLEAR) begin
			persist_lock_r <= 1'b0;
		end else if (cmd_run && op == OP_PW_UNLOCK) begin
			persist_lock_r <= 1'b1;
		end
	end

	// Sector pointer for per-sector commands
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			sector_sel_r <= '0;
		end else if (reg_wr_i && reg_addr_i == REG_SECTOR_SEL) begin
			sector_sel_r <= reg_wdata_i[SECTOR_W-1:0];
		end
	end

	// Program clears one bit, erase sets them all together
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			persistent_sector_bit_r <= '1;
		end else if (cmd_run && op == OP_PERSIST_PROG) begin
			persistent_sector_bit_r[sector_sel_r] <= 1'b0;
		end else if (cmd_run && op == OP_PERSIST_ERASE) begin
			persistent_sector_bit_r <= '1;
		end
	end

	// Volatile: any reset unprotects, writes allowed without write enable
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || any_rst) begin
			dynamic_sector_bit_r <= '1;
		end else if (cmd_go && regs_writable && op == OP_DYNAMIC_WRITE) begin
			dynamic_sector_bit_r[sector_sel_r] <= reg_wdata_i[ARG_DYB_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Range protection per sector
	// ----------------------------------------------------------------
	logic [8:0] range_size;
	logic [SECTORS-1:0] range_hit, sector_prot;

	// Level 1 covers a 64th, each step doubles, 7 covers everything
	always_comb begin
		if (level_r == LEVEL_RST) begin
			range_size = 9'h000;
		end else if (level_r == LEVEL_ALL) begin
			range_size = SECTORS_9;
		end else begin
			range_size = SECTORS_9 >> (3'h7 - level_r);
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < SECTORS; gi++) begin : g_sector
			localparam logic [8:0] IDX = 9'(gi);
			// Bottom counts up from zero, top counts down from the end
			assign range_hit[gi] = top_bottom_select_r ? (IDX < range_size)
				: (IDX >= SECTORS_9 - range_size);
			assign sector_prot[gi] = range_hit[gi] | ~persistent_sector_bit_r[gi] |
				~dynamic_sector_bit_r[gi];
		end
	endgenerate

	// Registered answer one cycle after the request
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			chk_done_o <= 1'b0;
			chk_protected_o <= 1'b0;
		end else begin
			chk_done_o <= chk_valid_i;
			if (chk_valid_i) begin
				chk_protected_o <= chk_otp_i ? freeze_r
					: sector_prot[chk_sector_i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------
	logic [DATA_W-1:0] rd_mux;

	always_comb begin
		rd_mux = '0;
		unique case (reg_addr_i)
			REG_STATUS: begin
				rd_mux[ST_BUSY_BIT] = (state_r != ST_IDLE);
				rd_mux[ST_WEL_BIT] = write_enable_latch_r;
				rd_mux[ST_LEVEL_LSB +: 3] = level_r;
				rd_mux[ST_ERR_BIT] = err_r;
				rd_mux[ST_SWD_BIT] = status_write_disable_r;
			end
			REG_CONFIG: begin
				rd_mux[CF_FREEZE_BIT] = freeze_r;
				rd_mux[CF_TB_BIT] = top_bottom_select_r;
			end
			REG_GUARD_MODE: rd_mux[MODE_LSB +: 2] = guard_mode_r;
			REG_LOCK: rd_mux[0] = persist_lock_r;
			REG_SECTOR_SEL: rd_mux[SECTOR_W-1:0] = sector_sel_r;
			REG_SECTOR_BITS: begin
				rd_mux[SB_PERSIST_BIT] = persistent_sector_bit_r[sector_sel_r];
				rd_mux[SB_DYNAMIC_BIT] = dynamic_sector_bit_r[sector_sel_r];
			end
			// Password and command words are write-only; unmapped reads zero
			default: rd_mux = '0;
		endcase
	end

	// Data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			reg_rdata_o <= '0;
		end else if (reg_rd_i) begin
			reg_rdata_o <= rd_mux;
		end else begin
			reg_rdata_o <= '0;
		end
	end

	// Status pins follow the sequencer
	assign busy_o = (state_r != ST_IDLE);
	assign prog_err_o = err_r;

endmodule

/* sector_write_protection_sva.sv */
`timescale 1ns/1ps
module sector_write_protection_chk
	import sector_guard_pkg::*;
#(
	parameter int PROG_CYC = PROG_CYC_DFLT,
	parameter int ERASE_CYC = ERASE_CYC_DFLT
) (
	// Clock and resets
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic hw_rst_n_i,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	// Check port and status
	input wire logic chk_valid_i,
	input wire logic chk_done_o,
	input wire logic chk_protected_o,
	input wire logic busy_o,
	input wire logic prog_err_o
);
	logic [3:0] hw_hist_r;
	logic [15:0] busy_run_r;
	logic cmd_wr;
	logic clr_wr;
	logic hw_quiet;

	// Pin history, since the pin reaches the flags through a synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			hw_hist_r <= 4'h0;
		end else begin
			hw_hist_r <= {hw_hist_r[2:0], hw_rst_n_i};
		end
	end
	assign hw_quiet = (&hw_hist_r) && hw_rst_n_i;
	assign cmd_wr = reg_wr_i && (reg_addr_i == REG_COMMAND);
	assign clr_wr = cmd_wr && (reg_wdata_i[3:0] == OP_CLEAR_STATUS);

	// Busy cycles without error; erase is the longest run
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i || !busy_o || prog_err_o) begin
			busy_run_r <= 16'h0000;
		end else begin
			busy_run_r <= busy_run_r + 16'h0001;
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	property p_done_next;
		chk_valid_i |=> chk_done_o;
	endproperty
	a_done_next: assert property (p_done_next)
		else $error("check answer missing");
	property p_done_cause;
		chk_done_o |-> $past(chk_valid_i);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("check answer without request");
	property p_prot_hold;
		!chk_done_o |-> $stable(chk_protected_o);
	endproperty
	a_prot_hold: assert property (p_prot_hold)
		else $error("protected result moved between checks");
	property p_err_busy;
		prog_err_o |-> busy_o;
	endproperty
	a_err_busy: assert property (p_err_busy)
		else $error("error flag without busy");
	property p_err_keep;
		prog_err_o && !reg_wr_i && hw_quiet |=> prog_err_o;
	endproperty
	a_err_keep: assert property (p_err_keep)
		else $error("error flag dropped on its own");
	property p_clear;
		prog_err_o && clr_wr && hw_quiet |=> !prog_err_o && !busy_o;
	endproperty
	a_clear: assert property (p_clear)
		else $error("status clear did not release flags");
	property p_busy_cause;
		!busy_o && !cmd_wr |=> !busy_o;
	endproperty
	a_busy_cause: assert property (p_busy_cause)
		else $error("busy rose without command");
	property p_busy_bound;
		busy_o && !prog_err_o |-> busy_run_r < 16'(ERASE_CYC);
	endproperty
	a_busy_bound: assert property (p_busy_bound)
		else $error("busy run too long");

	// Main scenarios reached
	c_err: cover property ($rose(prog_err_o));
	c_prot: cover property (chk_done_o && chk_protected_o);
	c_busy_end: cover property ($fell(busy_o) && !prog_err_o);
endmodule

/* host_bus_model.sv */
`timescale 1ns/1ps
module host_bus_model
	import sector_guard_pkg::*;
(
	// Clock
	input wire logic clk_sys_i,
	// Register port towards the device
	output logic [ADDR_W-1:0] reg_addr_o,
	output logic [DATA_W-1:0] reg_wdata_o,
	output logic reg_wr_o,
	output logic reg_rd_o,
	input wire logic [DATA_W-1:0] reg_rdata_i
);
	// Idle bus at time zero
	initial begin
		reg_addr_o = '0;
		reg_wdata_o = '0;
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
	end

	// One write cycle; released lines invert so stale values never help
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_wdata_o <= d;
		reg_wr_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_o <= 1'b0;
		reg_addr_o <= ~a;
		reg_wdata_o <= ~d;
	endtask

	// One read cycle, data taken in the following cycle only
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_i);
		reg_addr_o <= a;
		reg_rd_o <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_o <= 1'b0;
		reg_addr_o <= ~a;
		#1;
		d = reg_rdata_i;
	endtask

	// Command word: opcode in the low nibble
	task automatic cmd(input logic [3:0] op, input logic [31:0] arg);
		wr(REG_COMMAND, arg | {28'h0, op});
	endtask

	// Nonvolatile change always preceded by write enable
	task automatic nv(input logic [3:0] op, input logic [31:0] arg);
		cmd(OP_WRITE_ENABLE, 32'h0);
		cmd(op, arg);
	endtask
endmodule

/* tb_sector_write_protection.sv */
`timescale 1ns/1ps
module tb_sector_write_protection;
	import sector_guard_pkg::*;
	localparam int PROG = 4;
	localparam int ERASE = 8;
	localparam int GAP = 16;
	localparam logic [63:0] PW = 64'h0123_4567_89AB_CDEF;
	logic clk_sys_i, rst_n_i, hw_rst_n_i, soft_rst_i, wp_n_i;
	logic [ADDR_W-1:0] reg_addr_i;
	logic [DATA_W-1:0] reg_wdata_i, reg_rdata_o;
	logic reg_wr_i, reg_rd_i, chk_valid_i, chk_otp_i;
	logic [SECTOR_W-1:0] chk_sector_i;
	logic chk_done_o, chk_protected_o, busy_o, prog_err_o;
	logic [2:0] r_lvl[32];
	logic r_sel[32];
	logic [7:0] r_sec[32];
	logic r_exp[32];
	logic [31:0] d;
	int error_cnt = 0;
	int comparisons = 0;
	int n;

	sector_write_protection #(.PROG_CYC(PROG), .ERASE_CYC(ERASE), .UNLOCK_GAP(GAP))
		sector_write_protection_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.hw_rst_n_i(hw_rst_n_i), .soft_rst_i(soft_rst_i), .wp_n_i(wp_n_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .chk_valid_i(chk_valid_i),
		.chk_sector_i(chk_sector_i), .chk_otp_i(chk_otp_i), .chk_done_o(chk_done_o),
		.chk_protected_o(chk_protected_o), .busy_o(busy_o), .prog_err_o(prog_err_o));
	host_bus_model host_bus_model_i (.clk_sys_i(clk_sys_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .reg_wr_o(reg_wr_i), .reg_rd_o(reg_rd_i),
		.reg_rdata_i(reg_rdata_o));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] v;
		host_bus_model_i.rd(a, v);
		check(v, exp);
	endtask
	// One protection query; sector line inverted once released
	task automatic chk_sec(input logic [7:0] s, input logic otp, input logic exp);
		@(posedge clk_sys_i);
		chk_valid_i <= 1'b1;
		chk_sector_i <= s;
		chk_otp_i <= otp;
		@(posedge clk_sys_i);
		chk_valid_i <= 1'b0;
		chk_sector_i <= ~s;
		#1;
		check({31'h0, chk_done_o}, 32'h1);
		check({31'h0, chk_protected_o}, {31'h0, exp});
	endtask
	// Busy length in cycles, bounded so a stuck flag ends the run
	task automatic busy_len(input int exp);
		int c;
		c = 0;
		#1;
		while (busy_o === 1'b1 && c < 100) begin
			@(posedge clk_sys_i);
			#1;
			c++;
		end
		if (c >= 100) begin
			error_cnt++;
			give_verdict();
		end
		check(c, exp);
	endtask
	// Failure shows as busy plus error until status clear
	task automatic fail_clear();
		#1;
		check({30'h0, busy_o, prog_err_o}, 32'h3);
		host_bus_model_i.cmd(OP_CLEAR_STATUS, 32'h0);
		#1;
		check({30'h0, busy_o, prog_err_o}, 32'h0);
	endtask
	task automatic hw_pulse();
		@(posedge clk_sys_i);
		hw_rst_n_i <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
		hw_rst_n_i <= 1'b1;
		repeat (4) @(posedge clk_sys_i);
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n_i = 1'b0;
		hw_rst_n_i = 1'b1;
		soft_rst_i = 1'b0;
		wp_n_i = 1'b1;
		chk_valid_i = 1'b0;
		chk_sector_i = '0;
		chk_otp_i = 1'b0;
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		// Factory state
		rd_chk(REG_STATUS, 32'h0);
		rd_chk(REG_GUARD_MODE, {29'h0, MODE_NONE, 1'b0});
		rd_chk(REG_LOCK, 32'h1);
		host_bus_model_i.wr(REG_SECTOR_SEL, 32'h9);
		rd_chk(REG_SECTOR_BITS, 32'h3);
		chk_sec(8'h09, 1'b0, 1'b0);
		chk_sec(8'h00, 1'b1, 1'b0);
		$display("test reset values done");
		// Range rows: both edges of every level for both selectors
		for (int i = 0; i < 32; i++) begin
			r_lvl[i] = i[4:2];
			r_sel[i] = i[1];
			n = (i[4:2] == 3'h7) ? 256 : (i[4:2] == 3'h0) ? 0 : (256 >> (7 - i[4:2]));
			r_sec[i] = 8'((i[1] ? n - 1 + i[0] : 256 - n - i[0]) & 255);
			r_exp[i] = i[1] ? (int'(r_sec[i]) < n) : (int'(r_sec[i]) >= 256 - n);
		end
		for (int i = 0; i < 32; i++) begin
			host_bus_model_i.nv(OP_REG_WRITE, {10'h0, r_sel[i], 10'h0, r_lvl[i], 8'h0});
			chk_sec(r_sec[i], 1'b0, r_exp[i]);
		end
		$display("test range rows done");
		// Range and dynamic bit combined
		host_bus_model_i.nv(OP_REG_WRITE, 32'h100);
		host_bus_model_i.wr(REG_SECTOR_SEL, 32'h3);
		host_bus_model_i.cmd(OP_DYNAMIC_WRITE, 32'h0);
		chk_sec(8'h03, 1'b0, 1'b1);
		chk_sec(8'hFF, 1'b0, 1'b1);
		chk_sec(8'h64, 1'b0, 1'b0);
		host_bus_model_i.cmd(OP_DYNAMIC_WRITE, 32'h100);
		chk_sec(8'h03, 1'b0, 1'b0);
		host_bus_model_i.nv(OP_REG_WRITE, 32'h0);
		$display("test dynamic bits done");
		// Persistent bit program and erase
		host_bus_model_i.wr(REG_SECTOR_SEL, 32'h7);
		host_bus_model_i.nv(OP_PERSIST_PROG, 32'h0);
		busy_len(PROG);
		rd_chk(REG_SECTOR_BITS, 32'h2);
		chk_sec(8'h07, 1'b0, 1'b1);
		chk_sec(8'h08, 1'b0, 1'b0);
		host_bus_model_i.nv(OP_PERSIST_ERASE, 32'h0);
		busy_len(ERASE);
		chk_sec(8'h07, 1'b0, 1'b0);
		$display("test persistent bits done");
		// Persistent lock: clear, soft reset, refused program, hardware reset
		host_bus_model_i.cmd(OP_LOCK_CLEAR, 32'h0);
		rd_chk(REG_LOCK, 32'h0);
		@(posedge clk_sys_i);
		soft_rst_i <= 1'b1;
		@(posedge clk_sys_i);
		soft_rst_i <= 1'b0;
		rd_chk(REG_LOCK, 32'h0);
		host_bus_model_i.nv(OP_PERSIST_PROG, 32'h0);
		fail_clear();
		rd_chk(REG_SECTOR_BITS, 32'h3);
		hw_pulse();
		rd_chk(REG_LOCK, 32'h1);
		$display("test persistent lock done");
		// Write-protect pin with disable bit
		host_bus_model_i.nv(OP_REG_WRITE, 32'h8000);
		@(posedge clk_sys_i);
		wp_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		host_bus_model_i.nv(OP_REG_WRITE, 32'h700);
		host_bus_model_i.rd(REG_STATUS, d);
		check(d & 32'hFFFF_FFFD, 32'h80);
		@(posedge clk_sys_i);
		wp_n_i <= 1'b1;
		repeat (3) @(posedge clk_sys_i);
		host_bus_model_i.nv(OP_REG_WRITE, 32'h0);
		rd_chk(REG_STATUS, 32'h0);
		$display("test write protect pin done");
		// Mode selection; password stored before the mode bits
		host_bus_model_i.nv(OP_MODE_PROG, 32'h0);
		fail_clear();
		host_bus_model_i.wr(REG_PW_LO, PW[31:0]);
		host_bus_model_i.wr(REG_PW_HI, PW[63:32]);
		host_bus_model_i.nv(OP_PW_PROG, 32'h0);
		busy_len(PROG);
		host_bus_model_i.nv(OP_MODE_PROG, {21'h0, MODE_PASSWORD, 9'h0});
		busy_len(PROG);
		rd_chk(REG_GUARD_MODE, {29'h0, MODE_PASSWORD, 1'b0});
		host_bus_model_i.nv(OP_MODE_PROG, {21'h0, MODE_PERSIST, 9'h0});
		fail_clear();
		rd_chk(REG_GUARD_MODE, {29'h0, MODE_PASSWORD, 1'b0});
		hw_pulse();
		rd_chk(REG_LOCK, 32'h0);
		host_bus_model_i.wr(REG_PW_LO, ~PW[31:0]);
		host_bus_model_i.cmd(OP_PW_UNLOCK, 32'h0);
		fail_clear();
		rd_chk(REG_LOCK, 32'h0);
		repeat (GAP + 4) @(posedge clk_sys_i);
		host_bus_model_i.wr(REG_PW_LO, PW[31:0]);
		host_bus_model_i.cmd(OP_PW_UNLOCK, 32'h0);
		busy_len(1);
		rd_chk(REG_LOCK, 32'h1);
		$display("test password mode done");
		// Freeze: level kept, no error, OTP refused, only power-on clears
		host_bus_model_i.nv(OP_REG_WRITE, 32'h0001_0700);
		rd_chk(REG_CONFIG, 32'h1);
		chk_sec(8'h00, 1'b1, 1'b1);
		host_bus_model_i.nv(OP_REG_WRITE, 32'h0);
		rd_chk(REG_STATUS, 32'h1C);
		chk_sec(8'h00, 1'b0, 1'b1);
		hw_pulse();
		rd_chk(REG_CONFIG, 32'h1);
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd_chk(REG_CONFIG, 32'h0);
		$display("test freeze done");
		give_verdict();
	end
endmodule

bind sector_write_protection sector_write_protection_chk #(.PROG_CYC(PROG_CYC),
	.ERASE_CYC(ERASE_CYC)) sector_write_protection_chk_i (.clk_sys_i(clk_sys_i),
	.rst_n_i(rst_n_i), .hw_rst_n_i(hw_rst_n_i), .reg_addr_i(reg_addr_i),
	.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .chk_valid_i(chk_valid_i),
	.chk_done_o(chk_done_o), .chk_protected_o(chk_protected_o), .busy_o(busy_o),
	.prog_err_o(prog_err_o));
